// file: cfr_regs.sv
`timescale 1ns/1ps
`include "cfr_defs.svh"
module cfr_regs
    import cfr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // register port from the control interface
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // analog fault detectors, asynchronous
    input wire logic [1:0] dac_gate_fault_i,
    input wire logic [1:0] dac_short_fault_i,
    input wire logic analog_regulator_short_i,
    input wire logic [1:0] adc_overload_recovery_i,
    // on-chip dac status, same clock
    input wire logic [1:0] dac_powering_up_i,
    input wire logic [1:0] dac_fault_mask_i,
    // fault results
    output logic [1:0] dac_powerdown_o,
    output logic analog_regulator_short_flag_o,
    output logic [1:0] adc_mute_o,
    // adc power tuning
    output logic adc_modclk_halve_o,
    output logic adc_decim_order_sel_o,
    output logic adc_fir_skip_o,
    output logic adc_lowpower_filter_o,
    // dac power tuning
    output logic dac_modclk_halve_o,
    output logic dac_fir_segmenter_skip_o,
    output logic dac_lowpower_filter_o,
    output logic dac_refcurrent_sel_o
);
    // merge written data into the writable bits only
    function automatic cfr_byte_t merge_rw(input cfr_byte_t old_v, input cfr_byte_t wr_v, input cfr_byte_t rw_m);
        merge_rw = (wr_v & rw_m) | (old_v & ~rw_m);
    endfunction

    // synchroniser chain for the asynchronous detector lines
    logic [6:0] sync_a; // first stage, read only by sync_b
    logic [6:0] sync_b; // second stage
    logic [6:0] sync_c; // third stage
    logic [6:0] filt; // accepted level, moves when b and c agree
    logic [6:0] raw_in; // packed detector inputs
    logic [6:0] agree; // b and c match

    // register storage, only writable bits ever become one
    cfr_byte_t dac_fault_config;
    cfr_byte_t overload_mute_config;
    cfr_byte_t adc_power_tuning;
    cfr_byte_t dac_power_tuning;

    // write strobes per register
    logic wr_fault;
    logic wr_mute;
    logic wr_adc_tune;
    logic wr_dac_tune;
    cfr_byte_t rd_mux; // read data before the output flop
    cfr_byte_t fault_view; // fault register as software sees it
    logic status_flag; // any channel held down

    // filtered detector levels
    logic [1:0] vg_f;
    logic [1:0] sc_f;
    logic analog_regulator_f;
    logic [1:0] ovl_f;

    cfr_fault_if flt_bus ();

    // pack inputs; order is fixed so the filter indexes line up
    assign raw_in = {adc_overload_recovery_i, analog_regulator_short_i, dac_short_fault_i, dac_gate_fault_i};
    assign agree = ~(sync_b ^ sync_c);

    // three-flop chain; a glitch seen by only one stage is dropped
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
            sync_c <= 7'h00;
            filt <= 7'h00;
        end
        else
        begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
            filt <= (agree & sync_c) | (~agree & filt);
        end
    end

    assign vg_f = filt[1:0];
    assign sc_f = filt[3:2];
    assign analog_regulator_f = filt[4];
    assign ovl_f = filt[6:5];

    // address decode for writes
    assign wr_fault = reg_wr_i && (reg_addr_i == `CFR_ADDR_DAC_FAULT_CONFIG);
    assign wr_mute = reg_wr_i && (reg_addr_i == `CFR_ADDR_OVERLOAD_MUTE_CONFIG);
    assign wr_adc_tune = reg_wr_i && (reg_addr_i == `CFR_ADDR_ADC_POWER_TUNING);
    assign wr_dac_tune = reg_wr_i && (reg_addr_i == `CFR_ADDR_DAC_POWER_TUNING);

    // register writes; read-only and reserved bits are never stored
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            dac_fault_config <= `CFR_RST_DAC_FAULT_CONFIG;
            overload_mute_config <= `CFR_RST_OVERLOAD_MUTE_CONFIG;
            adc_power_tuning <= `CFR_RST_ADC_POWER_TUNING;
            dac_power_tuning <= `CFR_RST_DAC_POWER_TUNING;
        end
        else
        begin
            if (wr_fault)
                dac_fault_config <= merge_rw(dac_fault_config, reg_wdata_i, `CFR_RW_DAC_FAULT_CONFIG);
            if (wr_mute)
                overload_mute_config <= merge_rw(overload_mute_config, reg_wdata_i, `CFR_RW_OVERLOAD_MUTE_CONFIG);
            if (wr_adc_tune)
                adc_power_tuning <= merge_rw(adc_power_tuning, reg_wdata_i, `CFR_RW_ADC_POWER_TUNING);
            if (wr_dac_tune)
                dac_power_tuning <= merge_rw(dac_power_tuning, reg_wdata_i, `CFR_RW_DAC_POWER_TUNING);
        end
    end

    // live status bit overlays the stored fault register
    assign status_flag = |flt_bus.powerdown;
    assign fault_view = (dac_fault_config & `CFR_RW_DAC_FAULT_CONFIG) |
        {4'h0, status_flag, 3'h0};

    // read select; unmapped addresses and reserved bits read zero
    assign rd_mux = (reg_addr_i == `CFR_ADDR_DAC_FAULT_CONFIG) ? fault_view :
        (reg_addr_i == `CFR_ADDR_OVERLOAD_MUTE_CONFIG) ? (overload_mute_config & `CFR_RW_OVERLOAD_MUTE_CONFIG) :
        (reg_addr_i == `CFR_ADDR_ADC_POWER_TUNING) ? (adc_power_tuning & `CFR_RW_ADC_POWER_TUNING) :
        (reg_addr_i == `CFR_ADDR_DAC_POWER_TUNING) ? (dac_power_tuning & `CFR_RW_DAC_POWER_TUNING) : 8'h00;

    // read data register, holds between reads
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
            reg_rdata_o <= rd_mux;
    end

    // fault controller hookup
    assign flt_bus.policy = cfr_pd_policy_e'(dac_fault_config[`CFR_POLICY_MSB:`CFR_POLICY_LSB]);
    assign flt_bus.recovery_manual = dac_fault_config[`CFR_RECOVERY_BIT];
    assign flt_bus.exempt = dac_fault_config[`CFR_EXEMPT_BIT];
    assign flt_bus.detect_off = dac_fault_config[`CFR_DETECT_OFF_BIT];
    // any write to the fault register releases manually held channels whose fault is gone
    assign flt_bus.release_req = wr_fault;
    assign flt_bus.vg_fault = vg_f;
    assign flt_bus.sc_fault = sc_f;
    assign flt_bus.powering_up = dac_powering_up_i;
    assign flt_bus.fault_mask = dac_fault_mask_i;

    cfr_fault_pd i_cfr_fault_pd (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .flt(flt_bus)
    );

    assign dac_powerdown_o = flt_bus.powerdown;
    // regulator short flag, gated by its own detect switch
    assign analog_regulator_short_flag_o = analog_regulator_f && !dac_fault_config[`CFR_ANALOG_REGULATOR_OFF_BIT];
    // overload-recovery mutes, one enable per channel
    assign adc_mute_o[0] = ovl_f[0] && overload_mute_config[`CFR_CH1_MUTE_BIT];
    assign adc_mute_o[1] = ovl_f[1] && overload_mute_config[`CFR_CH2_MUTE_BIT];

    // power-tuning selections straight from their flops
    assign adc_modclk_halve_o = adc_power_tuning[`CFR_ADC_HALVE_BIT];
    assign adc_decim_order_sel_o = adc_power_tuning[`CFR_ADC_ORDER_BIT];
    assign adc_fir_skip_o = adc_power_tuning[`CFR_ADC_FIR_BIT];
    assign adc_lowpower_filter_o = adc_power_tuning[`CFR_ADC_LP_BIT];
    assign dac_modclk_halve_o = dac_power_tuning[`CFR_DAC_HALVE_BIT];
    assign dac_fir_segmenter_skip_o = dac_power_tuning[`CFR_DAC_FIRSEG_BIT];
    assign dac_lowpower_filter_o = dac_power_tuning[`CFR_DAC_LP_BIT];
    assign dac_refcurrent_sel_o = dac_power_tuning[`CFR_DAC_IREF_BIT];

    // status read reflects held channels of the previous cycle
    property p_status_read;
        @(posedge clk_sys_i) disable iff (srst_i)
        (reg_rd_i && reg_addr_i == `CFR_ADDR_DAC_FAULT_CONFIG) |=>
            (reg_rdata_o[`CFR_STATUS_BIT] == $past(|dac_powerdown_o));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit does not match held channels");

    // reserved positions of the adc tuning register read zero, and bit 7 of the fault register
    property p_reserved_zero;
        @(posedge clk_sys_i) disable iff (srst_i)
        (reg_rd_i && reg_addr_i == `CFR_ADDR_ADC_POWER_TUNING) |=>
            ((reg_rdata_o & ~`CFR_RW_ADC_POWER_TUNING) == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved adc tuning bit read nonzero");

    property p_fault_rsvd_zero;
        @(posedge clk_sys_i) disable iff (srst_i)
        (reg_rd_i && reg_addr_i == `CFR_ADDR_DAC_FAULT_CONFIG) |=> (reg_rdata_o[7] == 1'b0);
    endproperty
    a_fault_rsvd_zero: assert property (p_fault_rsvd_zero) else $error("fault register bit 7 read nonzero");

    // writing ones to read-only bits leaves no trace on readback
    property p_ro_write_ignored;
        @(posedge clk_sys_i) disable iff (srst_i)
        (wr_mute && reg_wdata_i == 8'hFF) ##2 (reg_rd_i && reg_addr_i == `CFR_ADDR_OVERLOAD_MUTE_CONFIG && !reg_wr_i)
            |=> (reg_rdata_o == 8'h18);
    endproperty
    a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("read-only mute bits took a write");

    // writable tuning field follows a write on the next edge
    property p_adc_clk_write;
        @(posedge clk_sys_i) disable iff (srst_i)
        wr_adc_tune |=> (adc_modclk_halve_o == $past(reg_wdata_i[`CFR_ADC_HALVE_BIT]));
    endproperty
    a_adc_clk_write: assert property (p_adc_clk_write) else $error("adc clock halving not updated");

    property p_dac_iref_write;
        @(posedge clk_sys_i) disable iff (srst_i)
        wr_dac_tune |=> (dac_refcurrent_sel_o == $past(reg_wdata_i[`CFR_DAC_IREF_BIT]))
            && (dac_fir_segmenter_skip_o == $past(reg_wdata_i[`CFR_DAC_FIRSEG_BIT]));
    endproperty
    a_dac_iref_write: assert property (p_dac_iref_write) else $error("dac tuning fields not updated");

    // a steady overload level reaches the mute on the same edge the filter accepts it
    property p_ch1_mute;
        @(posedge clk_sys_i) disable iff (srst_i)
        ($rose(adc_overload_recovery_i[0]) && overload_mute_config[`CFR_CH1_MUTE_BIT]) ##1
            (adc_overload_recovery_i[0] && overload_mute_config[`CFR_CH1_MUTE_BIT]) [*3] |=> adc_mute_o[0];
    endproperty
    a_ch1_mute: assert property (p_ch1_mute) else $error("ch1 not muted in overload recovery");

    property p_ch2_nomute;
        @(posedge clk_sys_i) disable iff (srst_i)
        !overload_mute_config[`CFR_CH2_MUTE_BIT] |-> !adc_mute_o[1];
    endproperty
    a_ch2_nomute: assert property (p_ch2_nomute) else $error("ch2 muted while mute disabled");

    // regulator flag stays low while its detector is switched off
    property p_analog_regulator_off;
        @(posedge clk_sys_i) disable iff (srst_i)
        dac_fault_config[`CFR_ANALOG_REGULATOR_OFF_BIT] |-> !analog_regulator_short_flag_o;
    endproperty
    a_analog_regulator_off: assert property (p_analog_regulator_off) else $error("regulator flag raised while disabled");

    // detection off: no new power-down from a powered channel
    property p_detect_off;
        @(posedge clk_sys_i) disable iff (srst_i)
        (dac_fault_config[`CFR_DETECT_OFF_BIT] && !dac_powerdown_o[0]) |=> !dac_powerdown_o[0];
    endproperty
    a_detect_off: assert property (p_detect_off) else $error("ch0 powered down with detection off");

    // policy zero never takes a powered channel down
    property p_policy_ignore;
        @(posedge clk_sys_i) disable iff (srst_i)
        (flt_bus.policy == CFR_PD_IGNORE && !dac_powerdown_o[1]) |=> !dac_powerdown_o[1];
    endproperty
    a_policy_ignore: assert property (p_policy_ignore) else $error("ch1 powered down under ignore policy");

    // exemption: gate fault during power-up alone keeps channel up
    property p_exempt;
        @(posedge clk_sys_i) disable iff (srst_i)
        (dac_fault_config[`CFR_EXEMPT_BIT] && dac_powering_up_i[0] && !sc_f[0] && !dac_powerdown_o[0])
            |=> !dac_powerdown_o[0];
    endproperty
    a_exempt: assert property (p_exempt) else $error("gate fault powered ch0 down during exempt power-up");

    // auto recovery re-powers a channel once its fault is gone
    property p_auto_recover;
        @(posedge clk_sys_i) disable iff (srst_i)
        (!dac_fault_config[`CFR_RECOVERY_BIT] && dac_powerdown_o[0] && !vg_f[0] && !sc_f[0])
            |=> !dac_powerdown_o[0];
    endproperty
    a_auto_recover: assert property (p_auto_recover) else $error("ch0 not re-powered after fault cleared");
endmodule

// file: cfr_defs.svh
`ifndef CFR_DEFS_SVH
`define CFR_DEFS_SVH
// register offsets on the control port
`define CFR_ADDR_DAC_FAULT_CONFIG 8'h43
`define CFR_ADDR_OVERLOAD_MUTE_CONFIG 8'h4B
`define CFR_ADDR_ADC_POWER_TUNING 8'h4E
`define CFR_ADDR_DAC_POWER_TUNING 8'h4F
// reset values
`define CFR_RST_DAC_FAULT_CONFIG 8'h50
`define CFR_RST_OVERLOAD_MUTE_CONFIG 8'h00
`define CFR_RST_ADC_POWER_TUNING 8'h00
`define CFR_RST_DAC_POWER_TUNING 8'h00
// writable bits of each register
`define CFR_RW_DAC_FAULT_CONFIG 8'h77
`define CFR_RW_OVERLOAD_MUTE_CONFIG 8'h18
`define CFR_RW_ADC_POWER_TUNING 8'hE4
`define CFR_RW_DAC_POWER_TUNING 8'hA6
// dac_fault_config fields
`define CFR_POLICY_MSB 6
`define CFR_POLICY_LSB 5
`define CFR_RECOVERY_BIT 4
`define CFR_STATUS_BIT 3
`define CFR_EXEMPT_BIT 2
`define CFR_DETECT_OFF_BIT 1
`define CFR_ANALOG_REGULATOR_OFF_BIT 0
// overload_mute_config fields
`define CFR_CH1_MUTE_BIT 4
`define CFR_CH2_MUTE_BIT 3
// adc_power_tuning fields
`define CFR_ADC_HALVE_BIT 7
`define CFR_ADC_ORDER_BIT 6
`define CFR_ADC_FIR_BIT 5
`define CFR_ADC_LP_BIT 2
// dac_power_tuning fields
`define CFR_DAC_HALVE_BIT 7
`define CFR_DAC_FIRSEG_BIT 5
`define CFR_DAC_LP_BIT 2
`define CFR_DAC_IREF_BIT 1
`endif

// file: cfr_pkg.sv
package cfr_pkg;
    // power-down policy on dac driver faults
    typedef enum logic [1:0] {
        CFR_PD_IGNORE = 2'b00,
        CFR_PD_UNMASKED = 2'b01,
        CFR_PD_ANY = 2'b10,
        CFR_PD_RESERVED = 2'b11
    } cfr_pd_policy_e;
    // per-channel power state
    typedef enum logic {
        CFR_CH_POWERED = 1'b0,
        CFR_CH_HELD_DOWN = 1'b1
    } cfr_ch_state_e;
    // one register byte
    typedef logic [7:0] cfr_byte_t;
endpackage

// file: cfr_fault_if.sv
`timescale 1ns/1ps
interface cfr_fault_if;
    import cfr_pkg::*;
    cfr_pd_policy_e policy; // power-down policy
    logic recovery_manual; // 1: hold down until software writes
    logic exempt; // skip gate-voltage faults during power-up
    logic detect_off; // ignore driver faults
    logic release_req; // pulse: software wrote the fault register
    logic [1:0] vg_fault; // filtered gate-voltage faults
    logic [1:0] sc_fault; // filtered short-circuit faults
    logic [1:0] powering_up; // channels in power-up
    logic [1:0] fault_mask; // 1: fault masked
    logic [1:0] powerdown; // channels held down
    modport regs (output policy, output recovery_manual, output exempt, output detect_off,
                  output release_req, output vg_fault, output sc_fault, output powering_up,
                  output fault_mask, input powerdown);
    modport ctl (input policy, input recovery_manual, input exempt, input detect_off,
                 input release_req, input vg_fault, input sc_fault, input powering_up,
                 input fault_mask, output powerdown);
endinterface

// file: cfr_fault_pd.sv
`timescale 1ns/1ps
module cfr_fault_pd
    import cfr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // fault controls and power state
    cfr_fault_if.ctl flt
);
    cfr_ch_state_e state [2]; // per-channel state
    logic [1:0] live_fault; // detected fault now present
    logic [1:0] trip; // fault that the policy acts on
    logic [1:0] leave_ok; // conditions to re-power a channel
    logic policy_off; // policy ignores faults

    // detection gate and power-up exemption
    assign live_fault = {2{~flt.detect_off}} &
        (flt.sc_fault | (flt.vg_fault & ~({2{flt.exempt}} & flt.powering_up)));
    // unmasked-only or any fault, reserved code acts as ignore
    assign trip = (flt.policy == CFR_PD_ANY) ? live_fault :
        (flt.policy == CFR_PD_UNMASKED) ? (live_fault & ~flt.fault_mask) : 2'b00;
    assign policy_off = (flt.policy == CFR_PD_IGNORE) || (flt.policy == CFR_PD_RESERVED);
    // auto recovery on fault gone, manual waits for a software write
    assign leave_ok = ~live_fault & (flt.recovery_manual ? {2{flt.release_req}} : 2'b11);

    // channel state machines; a fresh trip wins over recovery
    always_ff @(posedge clk_sys_i)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (srst_i)
                state[i] <= CFR_CH_POWERED;
            else
                case (state[i])
                    CFR_CH_POWERED: if (trip[i]) state[i] <= CFR_CH_HELD_DOWN;
                    CFR_CH_HELD_DOWN: if (!trip[i] && (leave_ok[i] || policy_off)) state[i] <= CFR_CH_POWERED;
                    default: state[i] <= CFR_CH_POWERED;
                endcase
        end
    end

    assign flt.powerdown = {state[1] == CFR_CH_HELD_DOWN, state[0] == CFR_CH_HELD_DOWN};

    property p_manual_hold;
        @(posedge clk_sys_i) disable iff (srst_i)
        (flt.recovery_manual && !flt.release_req && !policy_off && flt.powerdown[0]) |=> flt.powerdown[0];
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("manual recovery released ch0 early");

    property p_trip_down;
        @(posedge clk_sys_i) disable iff (srst_i)
        (flt.policy == CFR_PD_ANY && !flt.detect_off && flt.sc_fault[1]) |=> flt.powerdown[1];
    endproperty
    a_trip_down: assert property (p_trip_down) else $error("short fault did not power ch1 down");
endmodule

// file: cfr_regs_bench.sv
`timescale 1ns/1ps
`include "cfr_defs.svh"
module cfr_regs_bench
    import cfr_pkg::*;
;
    // clock, reset and register port
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    // fault and status inputs
    logic [1:0] dac_gate_fault_i = 2'h0;
    logic [1:0] dac_short_fault_i = 2'h0;
    logic analog_regulator_short_i = 1'b0;
    logic [1:0] adc_overload_recovery_i = 2'h0;
    logic [1:0] dac_powering_up_i = 2'h0;
    logic [1:0] dac_fault_mask_i = 2'h0;
    // observed outputs
    logic [1:0] dac_powerdown_o;
    logic analog_regulator_short_flag_o;
    logic [1:0] adc_mute_o;
    logic adc_modclk_halve_o, adc_decim_order_sel_o, adc_fir_skip_o, adc_lowpower_filter_o;
    logic dac_modclk_halve_o, dac_fir_segmenter_skip_o, dac_lowpower_filter_o, dac_refcurrent_sel_o;
    int mismatches = 0;
    int check_count = 0;
    cfr_byte_t v;
    cfr_byte_t addr_tab [4] = '{`CFR_ADDR_DAC_FAULT_CONFIG, `CFR_ADDR_OVERLOAD_MUTE_CONFIG,
                                `CFR_ADDR_ADC_POWER_TUNING, `CFR_ADDR_DAC_POWER_TUNING};
    cfr_byte_t rst_tab [4] = '{`CFR_RST_DAC_FAULT_CONFIG, `CFR_RST_OVERLOAD_MUTE_CONFIG,
                               `CFR_RST_ADC_POWER_TUNING, `CFR_RST_DAC_POWER_TUNING};
    cfr_byte_t rw_tab [4] = '{`CFR_RW_DAC_FAULT_CONFIG, `CFR_RW_OVERLOAD_MUTE_CONFIG,
                              `CFR_RW_ADC_POWER_TUNING, `CFR_RW_DAC_POWER_TUNING};

    // 40 MHz clock
    always #12.5 clk_sys_i = ~clk_sys_i;

    cfr_regs i_cfr_regs (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .dac_gate_fault_i(dac_gate_fault_i), .dac_short_fault_i(dac_short_fault_i),
        .analog_regulator_short_i(analog_regulator_short_i), .adc_overload_recovery_i(adc_overload_recovery_i),
        .dac_powering_up_i(dac_powering_up_i), .dac_fault_mask_i(dac_fault_mask_i),
        .dac_powerdown_o(dac_powerdown_o), .analog_regulator_short_flag_o(analog_regulator_short_flag_o), .adc_mute_o(adc_mute_o),
        .adc_modclk_halve_o(adc_modclk_halve_o), .adc_decim_order_sel_o(adc_decim_order_sel_o),
        .adc_fir_skip_o(adc_fir_skip_o), .adc_lowpower_filter_o(adc_lowpower_filter_o),
        .dac_modclk_halve_o(dac_modclk_halve_o), .dac_fir_segmenter_skip_o(dac_fir_segmenter_skip_o),
        .dac_lowpower_filter_o(dac_lowpower_filter_o), .dac_refcurrent_sel_o(dac_refcurrent_sel_o));

    // one compare; four-state so an unknown never matches
    task automatic chk(input cfr_byte_t got, input cfr_byte_t exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
            mismatches++;
        end
    endtask

    // one-cycle write strobe, launched and dropped on falling edges
    task automatic wr(input cfr_byte_t a, input cfr_byte_t d);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask

    // read data is registered, so it is settled by the next falling edge
    task automatic rd(input cfr_byte_t a, input cfr_byte_t exp);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, exp, "read data");
    endtask

    // fault pins pass a three-flop filter, so allow eight cycles to settle
    task automatic settle();
        repeat (8) @(negedge clk_sys_i);
    endtask

    task automatic pd(input logic [1:0] exp);
        chk({6'h00, dac_powerdown_o}, {6'h00, exp}, "powerdown");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        repeat (8) @(negedge clk_sys_i);
        srst_i = 1'b0;
        // reset values, plus an unmapped address reading zero
        for (int i = 0; i < 4; i++)
            rd(addr_tab[i], rst_tab[i]);
        rd(8'h44, 8'h00);
        // walk a single one through every bit; only writable bits stick
        for (int i = 0; i < 4; i++)
            for (int b = 0; b < 8; b++)
            begin
                v = 8'h01 << b;
                wr(addr_tab[i], v);
                rd(addr_tab[i], v & rw_tab[i]);
                if (i == 2)
                    chk({4'h0, adc_modclk_halve_o, adc_decim_order_sel_o, adc_fir_skip_o, adc_lowpower_filter_o},
                        {4'h0, v[7], v[6], v[5], v[2]}, "adc tuning");
                if (i == 3)
                    chk({4'h0, dac_modclk_halve_o, dac_fir_segmenter_skip_o, dac_lowpower_filter_o,
                        dac_refcurrent_sel_o}, {4'h0, v[7], v[5], v[2], v[1]}, "dac tuning");
            end
        // all ones into the mute register: only the two enables stick
        wr(`CFR_ADDR_OVERLOAD_MUTE_CONFIG, 8'hFF);
        rd(`CFR_ADDR_OVERLOAD_MUTE_CONFIG, 8'h18);
        // overload mute per channel, only while enabled
        wr(`CFR_ADDR_OVERLOAD_MUTE_CONFIG, 8'h18);
        adc_overload_recovery_i = 2'b11;
        settle();
        chk({6'h00, adc_mute_o}, 8'h03, "mute both");
        wr(`CFR_ADDR_OVERLOAD_MUTE_CONFIG, 8'h10);
        chk({6'h00, adc_mute_o}, 8'h01, "mute ch1 only");
        wr(`CFR_ADDR_OVERLOAD_MUTE_CONFIG, 8'h08);
        chk({6'h00, adc_mute_o}, 8'h02, "mute ch2 only");
        adc_overload_recovery_i = 2'b00;
        settle();
        chk({6'h00, adc_mute_o}, 8'h00, "mute released");
        // regulator short flag and its disable
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h40);
        analog_regulator_short_i = 1'b1;
        settle();
        chk({7'h00, analog_regulator_short_flag_o}, 8'h01, "regulator flag");
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h41);
        chk({7'h00, analog_regulator_short_flag_o}, 8'h00, "regulator flag off");
        analog_regulator_short_i = 1'b0;
        // any-fault policy with automatic recovery
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h40);
        dac_short_fault_i = 2'b01;
        settle();
        pd(2'b01);
        rd(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h48);
        dac_short_fault_i = 2'b00;
        settle();
        pd(2'b00);
        rd(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h40);
        // manual recovery holds the channel until software writes
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h50);
        dac_short_fault_i = 2'b10;
        settle();
        dac_short_fault_i = 2'b00;
        settle();
        pd(2'b10);
        rd(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h58);
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h50);
        repeat (3) @(negedge clk_sys_i);
        pd(2'b00);
        // unmasked-only policy: a masked fault is ignored
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h20);
        dac_fault_mask_i = 2'b01;
        dac_short_fault_i = 2'b01;
        settle();
        pd(2'b00);
        dac_fault_mask_i = 2'b00;
        settle();
        pd(2'b01);
        dac_short_fault_i = 2'b00;
        settle();
        pd(2'b00);
        // ignore policy, reserved policy and detector disable never trip
        for (int k = 0; k < 3; k++)
        begin
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'h60 : 8'h42;
            wr(`CFR_ADDR_DAC_FAULT_CONFIG, v);
            dac_short_fault_i = 2'b11;
            dac_gate_fault_i = 2'b11;
            settle();
            pd(2'b00);
            dac_short_fault_i = 2'b00;
            dac_gate_fault_i = 2'b00;
            settle();
        end
        // gate fault during power-up: exempt, then not
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h44);
        dac_powering_up_i = 2'b01;
        dac_gate_fault_i = 2'b01;
        settle();
        pd(2'b00);
        wr(`CFR_ADDR_DAC_FAULT_CONFIG, 8'h40);
        settle();
        pd(2'b01);
        dac_gate_fault_i = 2'b00;
        settle();
        pd(2'b00);
        tally_and_finish();
    end
endmodule
